//--- logic/lrf_pkg.sv
package lrf_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_RAMP = 8'h09;
  localparam logic [7:0] ADDR_TRANS = 8'h0A;
  localparam logic [7:0] ADDR_FLASH = 8'h0B;
  localparam logic [7:0] ADDR_AFUP = 8'h0C;
  localparam logic [7:0] ADDR_AFLO = 8'h0D;
  localparam logic [7:0] ADDR_FLT1 = 8'h0E;
  localparam logic [7:0] ADDR_FLT2 = 8'h0F;
  localparam logic [7:0] RST_RAMP = 8'h44;
  localparam logic [7:0] RST_TRANS = 8'h00;
  localparam logic [7:0] RST_FLASH = 8'h58;
  localparam logic [7:0] RST_AFUP = 8'h80;
  localparam logic [7:0] RST_AFLO = 8'h10;
  localparam logic [7:0] RST_FLT = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Writable / readable bits; reserved bits read zero
  localparam logic [7:0] TRANS_MASK = 8'h7F;
  localparam logic [7:0] FLT2_MASK = 8'hE0;
  // ==========================================================
  // Field positions
  localparam int HI_MSB = 7;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  localparam int PWM_MSB = 6;
  localparam int FLT2_OVP = 7;
  localparam int FLT2_UNDERVOLTAGE_LOCKOUT_FLAG = 6;
  localparam int FLT2_FLTO = 5;
  localparam int MODE_FLASH_BIT = 1;
  // ==========================================================
  // Decode scales
  localparam int RAMP_W = 24;
  localparam int BUS_W = 13;
  localparam int PWM_W = 9;
  localparam int LIM_W = 11;
  localparam int CUR_W = 17;
  localparam logic [RAMP_W-1:0] RAMP_MIN_US = 24'h000200;
  localparam logic [RAMP_W-1:0] RAMP_UNIT_US = 24'h0003E8;
  localparam logic [PWM_W-1:0] PWM_BASE_MS = 9'h002;
  localparam logic [BUS_W-1:0] BUS_LIN_STEP_MS = 13'h0040;
  localparam logic [BUS_W-1:0] BUS_HI_STEP_MS = 13'h0100;
  localparam logic [BUS_W-1:0] BUS_HI_OFS = 13'h0007;
  localparam logic [BUS_W-1:0] BUS_MAX_MS = 13'h1000;
  localparam logic [3:0] BUS_LAST_LIN = 4'h9;
  localparam logic [3:0] BUS_LAST_HI = 4'hD;
  localparam logic [3:0] BUS_TOP = 4'hF;
  localparam logic [LIM_W-1:0] FLASH_STEP_MS = 11'h064;
  localparam logic [CUR_W-1:0] FLASH_BASE_UA = 17'h073A0;
  localparam logic [CUR_W-1:0] FLASH_DIV = 17'h0000A;
  localparam logic [CUR_W-1:0] FLASH_OFS = 17'h0000C;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // ==========================================================
  // Serial slave
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2A; // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_DACK = 3'h3,
    ST_DATA = 3'h2,
    ST_WACK = 3'h6,
    ST_RDAT = 3'h7,
    ST_RACK = 3'h5
  } lrf_i2c_state_t;
endpackage

//--- logic/lrf_bus_if.sv
`timescale 1ns/1ns
interface lrf_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output wr, input rdata);
  modport slave (input addr, input wdata, input wr, output rdata);
endinterface

//--- logic/lrf_i2c_slave.sv
`timescale 1ns/1ns
module lrf_i2c_slave
  import lrf_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  lrf_bus_if.master bus
);
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic rise, fall, start, stop;
  lrf_i2c_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r, ptr_r, wdata_r;
  logic rw_r, first_r, inc_r, nack_r, wr_r, oe_r;

  // ==========================================================
  // Pin synchronisers; edges are judged on stage two and three only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end
    else
    begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
    end
  end

  assign rise = scl_s2 & ~scl_d;
  assign fall = ~scl_s2 & scl_d;
  assign start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ==========================================================
  // Byte engine: sample on SCL rise, drive on SCL fall
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      wdata_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      inc_r <= 1'b0;
      nack_r <= 1'b1;
      wr_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      wr_r <= 1'b0;
      if (start)
      begin
        state_r <= ST_DEV;
        cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end
      else if (stop)
      begin
        state_r <= ST_IDLE;
        oe_r <= 1'b0;
      end
      else if (rise)
      begin
        if (state_r == ST_DEV || state_r == ST_DATA || state_r == ST_RDAT)
        begin
          sh_r <= {sh_r[6:0], sda_s2};
          cnt_r <= cnt_r + 4'h1;
        end
        if (state_r == ST_RACK)
          nack_r <= sda_s2;
      end
      else if (fall)
      begin
        unique case (state_r)
          ST_IDLE: ;
          ST_DEV:
            if (cnt_r == BITS_PER_BYTE)
            begin
              cnt_r <= 4'h0;
              if (sh_r[7:1] == SLAVE_ADDR)
              begin
                state_r <= ST_DACK;
                oe_r <= 1'b1;
                rw_r <= sh_r[0];
              end
              else
                state_r <= ST_IDLE;
            end
          ST_DACK:
            if (rw_r)
            begin
              state_r <= ST_RDAT;
              tx_r <= {bus.rdata[6:0], 1'b0};
              oe_r <= ~bus.rdata[7];
            end
            else
            begin
              state_r <= ST_DATA;
              first_r <= 1'b1;
              oe_r <= 1'b0;
            end
          ST_DATA:
            if (cnt_r == BITS_PER_BYTE)
            begin
              cnt_r <= 4'h0;
              state_r <= ST_WACK;
              oe_r <= 1'b1;
              first_r <= 1'b0;
              if (first_r)
                ptr_r <= sh_r;
              else
              begin
                wdata_r <= sh_r;
                wr_r <= 1'b1;
                inc_r <= 1'b1;
              end
            end
          ST_WACK:
          begin
            state_r <= ST_DATA;
            oe_r <= 1'b0;
            inc_r <= 1'b0;
            if (inc_r)
              ptr_r <= ptr_r + 8'h01;
          end
          ST_RDAT:
            if (cnt_r == BITS_PER_BYTE)
            begin
              // Advance early so the next byte is ready at the ack fall
              cnt_r <= 4'h0;
              oe_r <= 1'b0;
              state_r <= ST_RACK;
              ptr_r <= ptr_r + 8'h01;
            end
            else
            begin
              oe_r <= ~tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          ST_RACK:
            if (!nack_r)
            begin
              state_r <= ST_RDAT;
              tx_r <= {bus.rdata[6:0], 1'b0};
              oe_r <= ~bus.rdata[7];
            end
            else
              state_r <= ST_IDLE;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  assign bus.addr = ptr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign sda_oe = oe_r;
endmodule // lrf_i2c_slave

//--- logic/lrf_regs.sv
`timescale 1ns/1ns
module lrf_regs
  import lrf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [1:0] OPERATING_MODE_SELECT,
  input wire logic [2:0] FAULT_OPEN,
  input wire logic [2:0] FAULT_SHORT,
  input wire logic FAULT_OVERCURRENT,
  input wire logic FAULT_OVERTEMP,
  input wire logic FAULT_OVERVOLTAGE,
  input wire logic FAULT_UNDERVOLTAGE,
  output logic [lrf_pkg::RAMP_W-1:0] RISE_RAMP_US,
  output logic [lrf_pkg::RAMP_W-1:0] FALL_RAMP_US,
  output logic [lrf_pkg::PWM_W-1:0] PULSE_TRANS_MS,
  output logic [lrf_pkg::BUS_W-1:0] BUS_TRANS_MS,
  output logic BUS_STEP_MODE,
  output logic FLASH_ON,
  output logic [lrf_pkg::LIM_W-1:0] FLASH_LIMIT_MS,
  output logic [lrf_pkg::CUR_W-1:0] FLASH_CURRENT_UA,
  output logic [7:0] AUTOFREQ_UPPER_VALUE,
  output logic [7:0] AUTOFREQ_LOWER_VALUE
);
  import lrf_pkg::*;

  lrf_bus_if bus ();
  logic sda_oe_w;
  logic [7:0] ramp_r, trans_r, flash_r, afup_r, aflo_r, flt1_r, flt2_r, rdata_r;
  logic [9:0] flt_s1, flt_s2;
  logic [7:0] ev1;
  logic [7:0] ev2;
  logic [3:0] rise_ramp_code, fall_ramp_code, bus_transition_code;
  logic [3:0] flash_limit_code, flash_current_code;
  logic [2:0] pulse_input_transition_code;
  logic flash_mode;
  logic [15:0] tick_cnt_r;
  logic tick_r;
  logic [LIM_W-1:0] ms_cnt_r, limit_ms;
  logic expired_r, flto_ev_r;
  logic [RAMP_W-1:0] rise_us_r, fall_us_r;
  logic [PWM_W-1:0] pulse_ms_r;
  logic [BUS_W-1:0] bus_ms_r;
  logic step_r, flash_on_r;
  logic [LIM_W-1:0] limit_out_r;
  logic [CUR_W-1:0] cur_out_r;

  // ==========================================================
  // Decoders
  function automatic logic [RAMP_W-1:0] ramp_us(input logic [3:0] code);
    if (code == 4'h0)
      ramp_us = RAMP_MIN_US;
    else
      ramp_us = RAMP_UNIT_US << (code - 4'h1);
  endfunction

  function automatic logic [BUS_W-1:0] bus_ms(input logic [3:0] code);
    logic [3:0] c;
    c = (code > BUS_LAST_HI && code != BUS_TOP) ? BUS_LAST_HI : code;
    if (c == 4'h0)
      bus_ms = '0;
    else if (c <= BUS_LAST_LIN)
      bus_ms = BUS_LIN_STEP_MS * ({9'h000, c} + 13'h0001);
    else if (c == BUS_TOP)
      bus_ms = BUS_MAX_MS;
    else
      bus_ms = BUS_HI_STEP_MS * ({9'h000, c} - BUS_HI_OFS);
  endfunction

  // ==========================================================
  // Serial slave
  lrf_i2c_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_slave (
    .clk(CLOCK),
    .rst_n(RST_N),
    .scl_in(SCL),
    .sda_in(SDA_IN),
    .sda_oe(sda_oe_w),
    .bus(bus.master)
  );

  // Open drain: line is only ever pulled low
  assign SDA_OE = sda_oe_w;
  always_ff @(posedge CLOCK)
    SDA_OUT <= 1'b0;

  // ==========================================================
  // Settings registers
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ramp_r <= RST_RAMP;
      trans_r <= RST_TRANS;
      flash_r <= RST_FLASH;
      afup_r <= RST_AFUP;
      aflo_r <= RST_AFLO;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        ADDR_RAMP: ramp_r <= bus.wdata;
        ADDR_TRANS: trans_r <= bus.wdata & TRANS_MASK;
        ADDR_FLASH: flash_r <= bus.wdata;
        ADDR_AFUP: afup_r <= bus.wdata;
        ADDR_AFLO: aflo_r <= bus.wdata;
        default: ;
      endcase
    end
  end

  assign rise_ramp_code = ramp_r[HI_MSB:HI_LSB];
  assign fall_ramp_code = ramp_r[LO_MSB:LO_LSB];
  assign pulse_input_transition_code = trans_r[PWM_MSB:HI_LSB];
  assign bus_transition_code = trans_r[LO_MSB:LO_LSB];
  assign flash_limit_code = flash_r[HI_MSB:HI_LSB];
  assign flash_current_code = flash_r[LO_MSB:LO_LSB];

  // ==========================================================
  // Fault flags
  // Fault detectors are analog and asynchronous, hence two flops
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      flt_s1 <= 10'h000;
      flt_s2 <= 10'h000;
    end
    else
    begin
      flt_s1 <= {FAULT_OPEN, FAULT_SHORT, FAULT_OVERCURRENT, FAULT_OVERTEMP, FAULT_OVERVOLTAGE, FAULT_UNDERVOLTAGE};
      flt_s2 <= flt_s1;
    end
  end

  // Channel 1 sits in the high bit of each group
  assign ev1 = {flt_s2[7], flt_s2[8], flt_s2[9], flt_s2[4], flt_s2[5], flt_s2[6],
                flt_s2[3], flt_s2[2]};

  always_comb
  begin
    ev2 = READ_ZERO;
    ev2[FLT2_OVP] = flt_s2[1];
    ev2[FLT2_UNDERVOLTAGE_LOCKOUT_FLAG] = flt_s2[0];
    ev2[FLT2_FLTO] = flto_ev_r;
  end

  // Writing zero clears, writing one keeps; a new event wins over the clear
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      flt1_r <= RST_FLT;
      flt2_r <= RST_FLT;
    end
    else
    begin
      if (bus.wr && bus.addr == ADDR_FLT1)
        flt1_r <= (flt1_r & bus.wdata) | ev1;
      else
        flt1_r <= flt1_r | ev1;
      if (bus.wr && bus.addr == ADDR_FLT2)
        flt2_r <= ((flt2_r & bus.wdata) | ev2) & FLT2_MASK;
      else
        flt2_r <= (flt2_r | ev2) & FLT2_MASK;
    end
  end

  // ==========================================================
  // Read-back, registered each cycle from the current pointer
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      rdata_r <= READ_ZERO;
    else
    begin
      unique case (bus.addr)
        ADDR_RAMP: rdata_r <= ramp_r;
        ADDR_TRANS: rdata_r <= trans_r;
        ADDR_FLASH: rdata_r <= flash_r;
        ADDR_AFUP: rdata_r <= afup_r;
        ADDR_AFLO: rdata_r <= aflo_r;
        ADDR_FLT1: rdata_r <= flt1_r;
        ADDR_FLT2: rdata_r <= flt2_r;
        default: rdata_r <= READ_ZERO;
      endcase
    end
  end
  assign bus.rdata = rdata_r;

  // ==========================================================
  // Flash limit timer on a millisecond enable
  assign flash_mode = OPERATING_MODE_SELECT[MODE_FLASH_BIT];
  assign limit_ms = FLASH_STEP_MS * {7'h00, flash_limit_code};

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == 16'(TICK_CYCLES - 1));
      if (tick_cnt_r == 16'(TICK_CYCLES - 1))
        tick_cnt_r <= 16'h0000;
      else
        tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  // Limit is counted from entry into flash mode; code 0 never expires
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ms_cnt_r <= '0;
      expired_r <= 1'b0;
      flto_ev_r <= 1'b0;
    end
    else
    begin
      flto_ev_r <= 1'b0;
      if (!flash_mode)
      begin
        ms_cnt_r <= '0;
        expired_r <= 1'b0;
      end
      else if (!expired_r && flash_limit_code != 4'h0 && tick_r)
      begin
        ms_cnt_r <= ms_cnt_r + 11'h001;
        if (ms_cnt_r + 11'h001 >= limit_ms)
        begin
          expired_r <= 1'b1;
          flto_ev_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Registered outputs; current divides first so the product fits its width
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      {rise_us_r, fall_us_r, pulse_ms_r, bus_ms_r, step_r, flash_on_r, limit_out_r, cur_out_r} <= '0;
    else
    begin
      rise_us_r <= ramp_us(rise_ramp_code);
      fall_us_r <= ramp_us(fall_ramp_code);
      pulse_ms_r <= PWM_BASE_MS << pulse_input_transition_code;
      bus_ms_r <= bus_ms(bus_transition_code);
      step_r <= (bus_transition_code == 4'h0);
      flash_on_r <= flash_mode & ~expired_r;
      limit_out_r <= flash_mode ? limit_ms : '0;
      cur_out_r <= flash_mode
        ? (FLASH_BASE_UA / FLASH_DIV) * (FLASH_OFS + {13'h0000, flash_current_code})
        : '0;
    end
  end

  assign RISE_RAMP_US = rise_us_r;
  assign FALL_RAMP_US = fall_us_r;
  assign PULSE_TRANS_MS = pulse_ms_r;
  assign BUS_TRANS_MS = bus_ms_r;
  assign BUS_STEP_MODE = step_r;
  assign FLASH_ON = flash_on_r;
  assign FLASH_LIMIT_MS = limit_out_r;
  assign FLASH_CURRENT_UA = cur_out_r;
  assign AUTOFREQ_UPPER_VALUE = afup_r;
  assign AUTOFREQ_LOWER_VALUE = aflo_r;
endmodule // lrf_regs

//--- tb/lrf_host_model.sv
`timescale 1ns/1ns
// ====================
// Serial host model
module lrf_host_model
#(
  parameter logic [6:0] DEV = 7'h2A
)
(
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic sda_low = 1'b0;
  // Pull-up on the wire: a released line reads high, never the last value
  assign sda = !(sda_low || sda_oe);
  initial scl = 1'b1;
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves a few clocks after SCL falls, so the slave never sees it change with SCL
  task automatic cond(input logic s1, input logic s2, input logic s3);
    pause(3);
    sda_low = s1;
    pause(7);
    scl = 1'b1;
    pause(10);
    sda_low = s2;
    pause(10);
    scl = s3;
  endtask
  task automatic start();
    cond(1'b0, 1'b1, 1'b0);
  endtask
  task automatic stop();
    cond(1'b1, 1'b0, 1'b1);
  endtask
  task automatic bit_io(input logic b, output logic r);
    pause(3);
    sda_low = !b;
    pause(7);
    scl = 1'b1;
    pause(10);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic rel9, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(rel9, s);
    ack = !s;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    xfer({DEV, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    xfer(v, 1'b1, q, k3);
    stop();
    ok = k1 && k2 && k3;
  endtask
  // Last byte is answered with a release, which ends the read
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] q;
    logic k;
    start();
    xfer({DEV, 1'b0}, 1'b1, q, k);
    xfer(a, 1'b1, q, k);
    start();
    xfer({DEV, 1'b1}, 1'b1, q, k);
    xfer(8'hFF, 1'b1, v, k);
    stop();
  endtask
endmodule // lrf_host_model

//--- tb/lrf_regs_properties.sv
`timescale 1ns/1ns
// ====================
// Port checker
module lrf_regs_properties
  import lrf_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_OE,
  input wire logic [1:0] OPERATING_MODE_SELECT,
  input wire logic [lrf_pkg::RAMP_W-1:0] RISE_RAMP_US,
  input wire logic [lrf_pkg::RAMP_W-1:0] FALL_RAMP_US,
  input wire logic [lrf_pkg::PWM_W-1:0] PULSE_TRANS_MS,
  input wire logic [lrf_pkg::BUS_W-1:0] BUS_TRANS_MS,
  input wire logic BUS_STEP_MODE,
  input wire logic FLASH_ON,
  input wire logic [lrf_pkg::LIM_W-1:0] FLASH_LIMIT_MS,
  input wire logic [lrf_pkg::CUR_W-1:0] FLASH_CURRENT_UA,
  input wire logic [7:0] AUTOFREQ_UPPER_VALUE,
  input wire logic [7:0] AUTOFREQ_LOWER_VALUE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  function automatic logic ramp_ok(input logic [23:0] v);
    ramp_ok = (v == 24'h000200);
    for (int k = 0; k < 15; k++)
      ramp_ok = ramp_ok || (v == (24'h0003E8 << k));
  endfunction
  reset_values_a: assert property ($rose(RST_N) |->
    AUTOFREQ_UPPER_VALUE == 8'h80 && AUTOFREQ_LOWER_VALUE == 8'h10) else $error("threshold reset values wrong");
  decode_reset_a: assert property ($rose(RST_N) |=> RISE_RAMP_US == 24'h001F40 &&
    FALL_RAMP_US == 24'h001F40 && PULSE_TRANS_MS == 9'h002 && BUS_STEP_MODE) else $error("decoded reset wrong");
  ramp_scale_a: assert property ($past(RST_N) |-> ramp_ok(RISE_RAMP_US) && ramp_ok(FALL_RAMP_US))
    else $error("ramp time off scale");
  pulse_scale_a: assert property ($past(RST_N) |-> $onehot(PULSE_TRANS_MS) && PULSE_TRANS_MS >= 9'h002)
    else $error("pulse transition off scale");
  bus_scale_a: assert property ($past(RST_N) |-> BUS_STEP_MODE ? BUS_TRANS_MS == 13'h0000 :
    (BUS_TRANS_MS inside {[13'h0080:13'h0600], 13'h1000})) else $error("bus transition off scale");
  flash_gate_a: assert property (!OPERATING_MODE_SELECT[1] |=>
    !FLASH_ON && FLASH_LIMIT_MS == 11'h000 && FLASH_CURRENT_UA == 17'h00000) else $error("flash outside mode");
  flash_current_a: assert property (OPERATING_MODE_SELECT[1] |=> FLASH_CURRENT_UA % 17'h00B90 == 17'h00000 &&
    FLASH_CURRENT_UA >= 17'h08AC0 && FLASH_CURRENT_UA <= 17'h13830) else $error("flash current off scale");
  flash_limit_a: assert property (OPERATING_MODE_SELECT[1] |=>
    FLASH_LIMIT_MS % 11'h064 == 11'h000 && FLASH_LIMIT_MS <= 11'h5DC) else $error("flash limit off scale");
  flash_source_a: assert property (FLASH_ON |-> $past(OPERATING_MODE_SELECT[1]))
    else $error("flash on without flash mode");
  ack_stable_a: assert property (SCL [*2] |-> $stable(SDA_OE)) else $error("data pull moved while clock high");
  cover property ($fell(FLASH_ON));
  cover property ($rose(SDA_OE));
  cover property ($fell(BUS_STEP_MODE));
endmodule // lrf_regs_properties
bind lrf_regs lrf_regs_properties chk_u (.CLOCK, .RST_N, .SCL, .SDA_OE, .OPERATING_MODE_SELECT, .RISE_RAMP_US,
  .FALL_RAMP_US, .PULSE_TRANS_MS, .BUS_TRANS_MS, .BUS_STEP_MODE, .FLASH_ON, .FLASH_LIMIT_MS, .FLASH_CURRENT_UA,
  .AUTOFREQ_UPPER_VALUE, .AUTOFREQ_LOWER_VALUE);

//--- tb/led_ramp_flash_fault_regs_bench.sv
`timescale 1ns/1ns
// ====================
// Bench top
module led_ramp_flash_fault_regs_bench;
  import lrf_pkg::*;
  // Short tick keeps the flash limit run to about a thousand cycles
  localparam int TICKS = 10;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda, sda_oe, sda_out, step, flash_on;
  logic [1:0] mode = 2'b00;
  logic [2:0] f_open = 3'h0;
  logic [2:0] f_short = 3'h0;
  logic f_oc = 1'b0, f_ot = 1'b0, f_ov = 1'b0, f_uv = 1'b0;
  logic [23:0] rise_us, fall_us;
  logic [8:0] pulse_ms;
  logic [12:0] bus_ms;
  logic [10:0] lim_ms;
  logic [16:0] cur_ua;
  logic [7:0] af_up, af_lo;
  int err_total = 0;
  int check_count = 0;
  always #10 clock = !clock;
  lrf_regs #(.TICK_CYCLES(TICKS), .SLAVE_ADDR(SLAVE_ADDR_DEF)) dut_u (.CLOCK(clock), .RST_N(rst_n), .SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .OPERATING_MODE_SELECT(mode), .FAULT_OPEN(f_open),
    .FAULT_SHORT(f_short), .FAULT_OVERCURRENT(f_oc), .FAULT_OVERTEMP(f_ot), .FAULT_OVERVOLTAGE(f_ov),
    .FAULT_UNDERVOLTAGE(f_uv), .RISE_RAMP_US(rise_us), .FALL_RAMP_US(fall_us), .PULSE_TRANS_MS(pulse_ms),
    .BUS_TRANS_MS(bus_ms), .BUS_STEP_MODE(step), .FLASH_ON(flash_on), .FLASH_LIMIT_MS(lim_ms),
    .FLASH_CURRENT_UA(cur_ua), .AUTOFREQ_UPPER_VALUE(af_up), .AUTOFREQ_LOWER_VALUE(af_lo));
  lrf_host_model #(.DEV(SLAVE_ADDR_DEF)) host_u (.clk(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic test_done();
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_u.rd(a, v);
    chk(v, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ok;
    host_u.wr(a, v, ok);
    chk(ok, 1'b1);
  endtask
  function automatic logic [12:0] bus_exp(input logic [3:0] c);
    case (c)
      4'h0: bus_exp = 13'h0000;
      4'hA: bus_exp = 13'h0300;
      4'hB: bus_exp = 13'h0400;
      4'hC: bus_exp = 13'h0500;
      4'hD, 4'hE: bus_exp = 13'h0600;
      4'hF: bus_exp = 13'h1000;
      default: bus_exp = 13'h0040 * (c + 4'h1);
    endcase
  endfunction
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask
  task automatic s_reset();
    chk({rise_us[15:0], fall_us[7:0]}, 24'h1F4040);
    chk({pulse_ms, step}, 10'h005);
    chk({af_up, af_lo}, 16'h8010);
    chk(sda_out, 1'b0);
    rdchk(ADDR_RAMP, 8'h44);
    rdchk(ADDR_TRANS, 8'h00);
    rdchk(ADDR_FLASH, 8'h58);
    rdchk(ADDR_AFUP, 8'h80);
    rdchk(ADDR_AFLO, 8'h10);
    rdchk(ADDR_FLT1, 8'h00);
    rdchk(ADDR_FLT2, 8'h00);
  endtask
  task automatic s_ramp();
    for (int c = 0; c < 16; c++)
    begin
      wr(ADDR_RAMP, {c[3:0], 4'hF - c[3:0]});
      chk(rise_us, (c == 0) ? 24'h000200 : (24'h0003E8 << (c - 1)));
      chk(fall_us, (c == 15) ? 24'h000200 : (24'h0003E8 << (14 - c)));
    end
    rdchk(ADDR_RAMP, 8'hF0);
  endtask
  task automatic s_trans();
    logic [7:0] v;
    for (int c = 0; c < 16; c++)
    begin
      v = {1'b1, c[2:0], c[3:0]};
      wr(ADDR_TRANS, v);
      chk(bus_ms, bus_exp(c[3:0]));
      chk(step, c == 0);
      chk(pulse_ms, 9'h002 << c[2:0]);
      rdchk(ADDR_TRANS, v & 8'h7F);
    end
  endtask
  task automatic s_flash();
    int n;
    wr(ADDR_FLASH, 8'h1F);
    mode = 2'b01;
    repeat (2) @(negedge clock);
    chk({flash_on, lim_ms}, 12'h000);
    chk(cur_ua, 17'h00000);
    mode = 2'b10;
    repeat (2) @(negedge clock);
    chk({flash_on, lim_ms}, 12'h864);
    chk(cur_ua, 17'h13830);
    n = 0;
    while (flash_on === 1'b1 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    // A hang is counted here and the run goes on to the closing report
    if (n == 3000)
    begin
      err_total++;
      $display("MISMATCH %0t: flash never ended", $time);
    end
    chk(n > 98 * TICKS && n < 102 * TICKS, 1'b1);
    rdchk(ADDR_FLT2, 8'h20);
    wr(ADDR_FLT2, 8'h00);
    rdchk(ADDR_FLT2, 8'h00);
    mode = 2'b00;
    wr(ADDR_FLASH, 8'h00);
    mode = 2'b11;
    repeat (1500) @(negedge clock);
    chk({flash_on, lim_ms}, 12'h800);
    chk(cur_ua, 17'h08AC0);
    mode = 2'b00;
  endtask
  task automatic s_fault();
    // Open ch1+ch3, short ch2, over-current, over-voltage, undervoltage
    {f_open, f_short, f_oc, f_ot, f_ov, f_uv} = 10'h2AB;
    repeat (6) @(negedge clock);
    {f_open, f_short, f_oc, f_ot, f_ov, f_uv} = 10'h000;
    rdchk(ADDR_FLT1, 8'hAA);
    rdchk(ADDR_FLT2, 8'hC0);
    wr(ADDR_FLT1, 8'h82);
    rdchk(ADDR_FLT1, 8'h82);
    wr(ADDR_FLT2, 8'h1F);
    rdchk(ADDR_FLT2, 8'h00);
    // Short on ch3 and over-temperature
    {f_short, f_ot} = 4'h9;
    repeat (6) @(negedge clock);
    {f_short, f_ot} = 4'h0;
    rdchk(ADDR_FLT1, 8'h87);
  endtask
  task automatic s_misc();
    logic [7:0] q;
    logic k;
    host_u.start();
    host_u.xfer({SLAVE_ADDR_DEF, 1'b0}, 1'b1, q, k);
    host_u.xfer(ADDR_AFUP, 1'b1, q, k);
    host_u.xfer(8'h5A, 1'b1, q, k);
    host_u.xfer(8'hA5, 1'b1, q, k);
    host_u.stop();
    chk({af_up, af_lo}, 16'h5AA5);
    rdchk(ADDR_AFLO, 8'hA5);
    host_u.wr(8'h20, 8'h77, k);
    rdchk(8'h20, 8'h00);
    host_u.start();
    host_u.xfer({SLAVE_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, q, k);
    host_u.stop();
    chk(k, 1'b0);
  endtask
  initial
  begin
    do_reset();
    s_reset();
    s_ramp();
    s_trans();
    s_flash();
    s_fault();
    s_misc();
    do_reset();
    s_reset();
    test_done();
  end
endmodule // led_ramp_flash_fault_regs_bench
